// ---- rtl/acr_ctrl_two.sv ----
/*
  Second control register of a 3-axis accelerometer: self-test enable,
  self-clearing soft reset with standby-first boot, sleep and wake oversampling
  modes, and auto-sleep with FIFO flush on sleep/wake transitions.
  Assumes the serial front end presents decoded accesses synchronous to clk,
  that the run-state logic drops runActive when asked for standby, and that
  resetPin is already synchronous.
*/
// How it works
// - self-test bit 7 turns self-test on/off
// - self-test shifts every axis output level
// - soft reset bit 6 starts software reset
// - boot reloads all registers with defaults
// - from standby the reboot starts at once
// - from active, go standby first, then reboot
// - high pulse on reset pin resets everything
// - reset also clears serial interface logic
// - soft reset bit self-clears after boot
// - bits 4:3 pick the sleep oversampling mode
// - codes: normal, lownoise-lowpower, highres, lowpower
// - bits 1:0 pick the wake oversampling mode
// - auto-sleep: transitions flush FIFO, reset counters
// - run-state zero is standby, reset standby
`timescale 1ns/100ps
`default_nettype none
module acr_ctrl_two #(
  parameter int unsigned BOOT_LEN = acr_pkg::BOOT_CYCLES
) (
  input wire logic clk, // core clock, 250 MHz
  input wire logic rst, // async reset, active high
  input wire acr_pkg::acr_regreq_type regReq, // register access
  output logic [7:0] regRdData, // read data, one cycle after rdEn
  output logic regRdValid, // read data valid pulse
  input wire logic resetPin, // external reset pin, active high
  input wire logic runActive, // run-state bit of control one, 1 = active
  input wire logic sleepState, // 1 while the system is in sleep mode
  output logic selfTestEn, // self-test drive to the transducer
  output acr_pkg::acr_osr_type sleepOsr, // sleep oversampling mode
  output acr_pkg::acr_osr_type wakeOsr, // wake oversampling mode
  output logic autoSleepEn, // auto-sleep enable
  output logic forceStandby, // asks run-state logic to go standby
  output logic blockReset, // resets functional block registers
  output logic serialReset, // holds i2c/spi logic in reset
  output logic fifoFlush, // one-cycle flush and counter reset
  output logic bootBusy // soft or pin reset in progress
);
  import acr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_BOOT = 3'b100
  } acr_state_type;

  acr_state_type state_reg, state_next;
  acr_ctrl_type ctrl_reg, ctrl_next;
  logic pinPrev_reg;
  logic sleepPrev_reg;
  logic forceStandby_reg, blockReset_reg, serialReset_reg;
  logic fifoFlush_reg, bootBusy_reg, rdValid_reg;
  logic [7:0] rdData_reg;
  logic addrHit, wrHit, pinRise, swTrigger, bootStart, bootDone, sleepEdge;
  acr_ctrl_type wrValue, bootValue;

  // access decode; writes are dropped while the serial logic is held in reset
  assign addrHit = (regReq.addr == CTRL2_ADDR);
  assign wrHit = regReq.wrEn && addrHit && !serialReset_reg;
  assign pinRise = resetPin && !pinPrev_reg;
  assign swTrigger = wrHit && regReq.data[RST_BIT] && (state_reg == ST_IDLE);
  assign sleepEdge = sleepState ^ sleepPrev_reg;

  // reset sequencer: standby first when active, then a timed boot
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (pinRise) begin
          state_next = ST_BOOT;
        end else if (swTrigger) begin
          state_next = runActive ? ST_WAIT : ST_BOOT;
        end
      end
      ST_WAIT: begin
        if (pinRise || !runActive) begin
          state_next = ST_BOOT;
        end
      end
      ST_BOOT: begin
        if (bootDone) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  assign bootStart = (state_next == ST_BOOT) && (state_reg != ST_BOOT);

  acr_boot_timer #(
    .LEN(BOOT_LEN)
  ) u_boot_timer (
    .clk(clk),
    .rst(rst),
    .start(bootStart),
    .done(bootDone)
  );

  // value written by software; a zero in the reset bit keeps its old state
  assign wrValue = '{
    selfTest: regReq.data[ST_BIT],
    rstTrig: ctrl_reg.rstTrig || regReq.data[RST_BIT],
    spare: regReq.data[SPARE_BIT],
    sleepOsr: acr_osr_type'(regReq.data[SMODS_MSB:SMODS_LSB]),
    autoSleep: regReq.data[SLPE_BIT],
    wakeOsr: acr_osr_type'(regReq.data[MODS_MSB:MODS_LSB])
  };

  // boot reloads defaults; a software boot that waited for standby keeps the trigger visible until done
  always_comb begin
    bootValue = acr_ctrl_type'(CTRL2_RESET);
    bootValue.rstTrig = ctrl_reg.rstTrig && !pinRise;
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    if (state_reg == ST_BOOT && bootDone) begin
      ctrl_next = acr_ctrl_type'(CTRL2_RESET);
    end else if (bootStart) begin
      ctrl_next = bootValue;
    end else if (wrHit && state_reg != ST_BOOT) begin
      ctrl_next = wrValue;
    end
  end

  // register and sequencer state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      ctrl_reg <= acr_ctrl_type'(CTRL2_RESET);
      pinPrev_reg <= 1'b0;
      sleepPrev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      pinPrev_reg <= resetPin;
      sleepPrev_reg <= sleepState;
    end
  end

  // control outputs; serial logic stays in reset for the whole boot so the
  // host quiet time starts from a clean interface
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      forceStandby_reg <= 1'b0;
      blockReset_reg <= 1'b0;
      serialReset_reg <= 1'b0;
      bootBusy_reg <= 1'b0;
      fifoFlush_reg <= 1'b0;
    end else begin
      forceStandby_reg <= (state_next == ST_WAIT);
      blockReset_reg <= (state_next == ST_BOOT);
      serialReset_reg <= (state_next == ST_BOOT);
      bootBusy_reg <= (state_next != ST_IDLE);
      fifoFlush_reg <= ctrl_reg.autoSleep && sleepEdge && (state_next == ST_IDLE);
    end
  end

  // read port; unmapped addresses read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_reg <= 8'h00;
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= regReq.rdEn && !serialReset_reg;
      rdData_reg <= addrHit ? ctrl_reg : RD_UNMAPPED;
    end
  end

  assign regRdData = rdData_reg;
  assign regRdValid = rdValid_reg;
  assign selfTestEn = ctrl_reg.selfTest;
  assign sleepOsr = ctrl_reg.sleepOsr;
  assign wakeOsr = ctrl_reg.wakeOsr;
  assign autoSleepEn = ctrl_reg.autoSleep;
  assign forceStandby = forceStandby_reg;
  assign blockReset = blockReset_reg;
  assign serialReset = serialReset_reg;
  assign fifoFlush = fifoFlush_reg;
  assign bootBusy = bootBusy_reg;

  // checks next to the logic they guard; a write that boots at once reloads defaults instead
  property p_selftest_write;
    @(posedge clk) disable iff (rst)
      (wrHit && state_reg == ST_IDLE && !pinRise && !(swTrigger && !runActive))
        |=> (selfTestEn == $past(regReq.data[ST_BIT]));
  endproperty
  a_selftest_write: assert property (p_selftest_write) else $error("self-test bit not taken");

  property p_sleep_osr_write;
    @(posedge clk) disable iff (rst)
      (wrHit && state_reg == ST_IDLE && !pinRise && !(swTrigger && !runActive))
        |=> (sleepOsr == $past(regReq.data[SMODS_MSB:SMODS_LSB]));
  endproperty
  a_sleep_osr_write: assert property (p_sleep_osr_write) else $error("sleep mode field not taken");

  property p_standby_first;
    @(posedge clk) disable iff (rst)
      (swTrigger && runActive && !pinRise) |=> (forceStandby && !blockReset) ##1 (forceStandby || blockReset);
  endproperty
  a_standby_first: assert property (p_standby_first) else $error("active reset skipped standby");

  property p_boot_at_once;
    @(posedge clk) disable iff (rst)
      (swTrigger && !runActive) |=> (blockReset && serialReset && !forceStandby);
  endproperty
  a_boot_at_once: assert property (p_boot_at_once) else $error("standby reset did not boot at once");

  property p_pin_reset;
    @(posedge clk) disable iff (rst)
      (pinRise && state_reg != ST_BOOT) |=> (blockReset && serialReset);
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin pulse did not reset");

  property p_reload_defaults;
    @(posedge clk) disable iff (rst)
      $rose(blockReset) |-> (!selfTestEn && !autoSleepEn && sleepOsr == OSR_NORMAL && wakeOsr == OSR_NORMAL);
  endproperty
  a_reload_defaults: assert property (p_reload_defaults) else $error("boot kept old settings");

  property p_self_clear;
    @(posedge clk) disable iff (rst)
      $fell(blockReset) |-> (!ctrl_reg.rstTrig && !bootBusy);
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("reset bit not cleared after boot");

  property p_zero_ignored;
    @(posedge clk) disable iff (rst)
      (wrHit && !regReq.data[RST_BIT] && state_reg == ST_IDLE && !pinRise) |=> !bootBusy;
  endproperty
  a_zero_ignored: assert property (p_zero_ignored) else $error("zero write started a reset");

  property p_flush;
    @(posedge clk) disable iff (rst)
      (autoSleepEn && sleepEdge && state_reg == ST_IDLE && !pinRise && !swTrigger) |=> fifoFlush;
  endproperty
  a_flush: assert property (p_flush) else $error("sleep transition did not flush");
endmodule
`default_nettype wire

// ---- rtl/acr_pkg.sv ----
/*
  Shared constants and types for the second accelerometer control register:
  the register address, reset value and field positions, the oversampling mode
  codes, the boot timing, and the packed carriers for register access and contents.
  Assumes nothing of its surroundings.
*/
package acr_pkg;

  // register address and reset value
  localparam logic [7:0] CTRL2_ADDR = 8'h2B;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // field positions inside the register
  localparam int unsigned ST_BIT = 7;
  localparam int unsigned RST_BIT = 6;
  localparam int unsigned SPARE_BIT = 5;
  localparam int unsigned SMODS_MSB = 4;
  localparam int unsigned SMODS_LSB = 3;
  localparam int unsigned SLPE_BIT = 2;
  localparam int unsigned MODS_MSB = 1;
  localparam int unsigned MODS_LSB = 0;

  // boot sequence length, a least time, so it rounds up to whole cycles
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned BOOT_TIME_PS = 64000;
  localparam int unsigned BOOT_CYCLES = (BOOT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // oversampling mode codes, shared by the sleep and wake fields
  typedef enum logic [1:0] {
    OSR_NORMAL = 2'h0,
    OSR_LOW_NOISE_LOW_POWER = 2'h1,
    OSR_HIGH_RES = 2'h2,
    OSR_LOW_POWER = 2'h3
  } acr_osr_type;

  // register contents, msb first, same layout as the register
  typedef struct packed {
    logic selfTest;
    logic rstTrig;
    logic spare;
    acr_osr_type sleepOsr;
    logic autoSleep;
    acr_osr_type wakeOsr;
  } acr_ctrl_type;

  // one register access from the serial front end
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] data;
  } acr_regreq_type;

endpackage

// ---- rtl/acr_boot_timer.sv ----
/*
  Boot sequence timer: a load-and-count-down counter that pulses done
  LEN + 1 cycles after start.
  Assumes start is a one-cycle pulse in the clk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module acr_boot_timer #(
  parameter int unsigned LEN = 16
) (
  input wire logic clk, // core clock
  input wire logic rst, // async reset, active high
  input wire logic start, // load the counter
  output logic done // one-cycle pulse at the end
);
  localparam int unsigned CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] LEN_C = CW'(LEN);
  localparam logic [CW-1:0] ONE_C = CW'(1);

  logic [CW-1:0] count_reg;
  logic done_reg;

  // a restart while counting simply reloads, so the boot is never cut short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= (count_reg == ONE_C) && !start;
      if (start) begin
        count_reg <= LEN_C;
      end else if (count_reg != '0) begin
        count_reg <= count_reg - ONE_C;
      end
    end
  end

  assign done = done_reg;
endmodule
`default_nettype wire

// ---- verif/acr_runstate_model.sv ----
/*
  Model of the run-state and sleep/wake logic beside the control register.
  Assumes clk and rst are the block's core clock and reset.
*/
`timescale 1ns/100ps
`default_nettype none
module acr_runstate_model (
  input wire logic clk, // core clock
  input wire logic rst, // async reset, active high
  input wire logic forceStandby, // standby request from the block
  input wire logic goActive, // one-cycle request to enter active
  input wire logic sleepReq, // wanted sleep state
  input wire logic [3:0] lag, // one less than the cycles taken to reach standby
  output logic runActive, // 1 = active, 0 = standby
  output logic sleepState // 1 while asleep
);
  logic [3:0] cnt_reg;
  // standby is slow on purpose: the block must wait, not assume
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      runActive <= 1'b0;
      cnt_reg <= 4'h0;
      sleepState <= 1'b0;
    end else begin
      sleepState <= sleepReq;
      if (forceStandby) begin
        if (cnt_reg == lag) runActive <= 1'b0;
        else cnt_reg <= cnt_reg + 4'h1;
      end else begin
        cnt_reg <= 4'h0;
        if (goActive) runActive <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
/*
  Self-checking bench for the second control register.
  Assumes the run-state model answers standby requests.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import acr_pkg::*;
  localparam int BL = 4;
  logic clk = 0, rst = 1, resetPin = 0, goActive = 0, sleepReq = 0;
  logic runActive, sleepState, regRdValid, selfTestEn, autoSleepEn;
  logic forceStandby, blockReset, serialReset, fifoFlush, bootBusy;
  logic [7:0] regRdData;
  acr_regreq_type regReq = '0;
  acr_osr_type sleepOsr, wakeOsr;
  int n_fail = 0, n_tests = 0, n;
  // core clock, 4 ns
  always #2 clk = ~clk;
  acr_ctrl_two #(.BOOT_LEN(BL)) u_acr_ctrl_two (.clk(clk), .rst(rst), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid), .resetPin(resetPin), .runActive(runActive),
    .sleepState(sleepState), .selfTestEn(selfTestEn), .sleepOsr(sleepOsr), .wakeOsr(wakeOsr),
    .autoSleepEn(autoSleepEn), .forceStandby(forceStandby), .blockReset(blockReset),
    .serialReset(serialReset), .fifoFlush(fifoFlush), .bootBusy(bootBusy));
  acr_runstate_model u_acr_runstate_model (.clk(clk), .rst(rst), .forceStandby(forceStandby),
    .goActive(goActive), .sleepReq(sleepReq), .lag(4'h3), .runActive(runActive),
    .sleepState(sleepState));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk) regReq.wrEn <= 1'b0;
    #1;
  endtask
  // a refused read must give no valid pulse
  task rd(input logic [7:0] a, input logic v, input logic [7:0] d);
    @(posedge clk) regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) regReq.rdEn <= 1'b0;
    #1;
    chk(regRdValid, v);
    if (v) chk(regRdData, d);
  endtask
  // counts flush pulses over the six cycles after the sleep request level is set
  task flush_count(input logic lvl, input logic [7:0] exp);
    n = 0;
    @(posedge clk) sleepReq <= lvl;
    repeat (6) begin
      @(posedge clk);
      #1;
      n += fifoFlush;
    end
    chk(n[7:0], exp);
  endtask
  task wait_rise;
    n = 0;
    while (blockReset !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 20) begin
      n_fail++;
      complete_run;
    end
  endtask
  // measures the boot length from its first cycle
  task boot_wait;
    n = 1;
    while (blockReset === 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      if (blockReset === 1'b1) n++;
    end
    if (n >= 40) begin
      n_fail++;
      complete_run;
    end
    chk(bootBusy, 8'h00);
    repeat (4) @(posedge clk);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL2_ADDR, 1'b1, CTRL2_RESET);
    rd(8'h2A, 1'b1, RD_UNMAPPED);
    for (int i = 0; i < 4; i++) begin
      wr(CTRL2_ADDR, {i[0], 2'b01, i[1:0], 1'b0, ~i[1:0]});
      chk(selfTestEn, i[0]);
      chk(sleepOsr, i[1:0]);
      chk(wakeOsr, {6'h00, ~i[1:0]});
      chk(bootBusy, 8'h00);
      rd(CTRL2_ADDR, 1'b1, {i[0], 2'b01, i[1:0], 1'b0, ~i[1:0]});
    end
    wr(8'h2C, 8'h00);
    chk(selfTestEn, 8'h01);
    wr(CTRL2_ADDR, 8'h04);
    chk(autoSleepEn, 8'h01);
    flush_count(1'b1, 8'h01);
    wr(CTRL2_ADDR, 8'h00);
    flush_count(1'b0, 8'h00);
    wr(CTRL2_ADDR, 8'hC5);
    chk(blockReset, 8'h01);
    chk(serialReset, 8'h01);
    boot_wait;
    chk(n[7:0], BL + 1);
    rd(CTRL2_ADDR, 1'b1, 8'h00);
    @(posedge clk) goActive <= 1'b1;
    @(posedge clk) goActive <= 1'b0;
    wr(CTRL2_ADDR, 8'h40);
    chk(forceStandby, 8'h01);
    chk(blockReset, 8'h00);
    wait_rise;
    chk(runActive, 8'h00);
    boot_wait;
    rd(CTRL2_ADDR, 1'b1, 8'h00);
    wr(CTRL2_ADDR, 8'h9B);
    @(posedge clk) resetPin <= 1'b1;
    @(posedge clk) resetPin <= 1'b0;
    wait_rise;
    rd(CTRL2_ADDR, 1'b0, 8'h00);
    boot_wait;
    rd(CTRL2_ADDR, 1'b1, 8'h00);
    chk(selfTestEn, 8'h00);
    complete_run;
  end
endmodule
`default_nettype wire
